//--- design/ser_group.sv
module ser_group
  import ser_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [14:0] cond_in,
  input wire logic wr_en,
  input wire logic [2:0] wr_part,
  input wire logic [14:0] wr_data,
  input wire logic preset,
  input wire logic rd_clear,
  output logic [14:0] cond_reg,
  output logic [14:0] rise_reg,
  output logic [14:0] fall_reg,
  output logic [14:0] event_reg,
  output logic [14:0] enable_reg,
  output logic summary_reg
);
  logic [14:0] sync1_reg;
  logic [14:0] sync2_reg;
  logic [14:0] sync3_reg;
  logic [14:0] cond_next;
  logic [14:0] set_bits;
  logic [14:0] event_next;
  logic [14:0] enable_next;
  logic [14:0] agree;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= SER_ZERO;
      sync2_reg <= SER_ZERO;
      sync3_reg <= SER_ZERO;
    end else begin
      sync1_reg <= cond_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Live state follows a bit once two stages agree
  always_comb begin
    agree = ~(sync2_reg ^ sync3_reg);
    cond_next = (agree & sync3_reg) | (~agree & cond_reg);
    set_bits = (rise_reg & cond_next & ~cond_reg)
             | (fall_reg & ~cond_next & cond_reg);
    event_next = (event_reg & ~{SER_W{rd_clear}}) | set_bits;
    if (preset) begin
      enable_next = SER_ENABLE_PRESET;
    end else if (wr_en && wr_part == SER_PART_MASK) begin
      enable_next = wr_data;
    end else begin
      enable_next = enable_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_reg <= SER_ZERO;
    end else begin
      cond_reg <= cond_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_reg <= SER_ZERO;
    end else begin
      event_reg <= event_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_reg <= SER_RISE_PRESET;
      fall_reg <= SER_FALL_PRESET;
      enable_reg <= SER_ENABLE_PRESET;
    end else begin
      enable_reg <= enable_next;
      if (preset) begin
        rise_reg <= SER_RISE_PRESET;
        fall_reg <= SER_FALL_PRESET;
      end else if (wr_en) begin
        if (wr_part == SER_PART_RISE) begin
          rise_reg <= wr_data;
        end
        if (wr_part == SER_PART_FALL) begin
          fall_reg <= wr_data;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_reg <= 1'b0;
    end else begin
      summary_reg <= |(event_next & enable_next);
    end
  end

  sequence rise_seen;
    ##1 1'b1;
  endsequence

  chk_rise_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rise_seen |-> ((event_reg & $past(rise_reg) & cond_reg & ~$past(cond_reg))
      == ($past(rise_reg) & cond_reg & ~$past(cond_reg))))
    else $error("rising change with filter set not latched");

  chk_fall_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 ((event_reg & $past(fall_reg) & ~cond_reg & $past(cond_reg))
      == ($past(fall_reg) & ~cond_reg & $past(cond_reg))))
    else $error("falling change with filter set not latched");

  chk_event_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 ((event_reg & ~$past(event_reg) & ~(($past(rise_reg) & cond_reg
      & ~$past(cond_reg)) | ($past(fall_reg) & ~cond_reg
      & $past(cond_reg)))) == SER_ZERO))
    else $error("flag set without a filtered change");

  chk_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_clear |=> ((event_reg & ~(($past(rise_reg) & cond_reg
      & ~$past(cond_reg)) | ($past(fall_reg) & ~cond_reg
      & $past(cond_reg)))) == SER_ZERO))
    else $error("flags survived a read");

  chk_summary_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
    summary_reg == |(event_reg & enable_reg))
    else $error("summary does not match masked flags");

  chk_preset_vals: assert property (@(posedge sys_clk) disable iff (!rst_n)
    preset |=> (rise_reg == SER_ALL_ONES && fall_reg == SER_ZERO
      && enable_reg == SER_ZERO))
    else $error("preset values wrong");
endmodule : ser_group

//--- design/ser_pkg.sv
package ser_pkg;
  localparam int SER_W = 15;
  localparam int SER_PARTS = 5;
  localparam int SER_GROUPS = 2;
  localparam logic [14:0] SER_ALL_ONES = 15'h7FFF;
  localparam logic [14:0] SER_ZERO = 15'h0000;
  // Preset values, also used at power-up
  localparam logic [14:0] SER_RISE_PRESET = 15'h7FFF;
  localparam logic [14:0] SER_FALL_PRESET = 15'h0000;
  localparam logic [14:0] SER_ENABLE_PRESET = 15'h0000;
  // Part codes inside a group
  localparam logic [2:0] SER_PART_LIVE = 3'h0;
  localparam logic [2:0] SER_PART_MASK = 3'h1;
  localparam logic [2:0] SER_PART_FLAGS = 3'h2;
  localparam logic [2:0] SER_PART_FALL = 3'h3;
  localparam logic [2:0] SER_PART_RISE = 3'h4;
  // Register indices
  localparam logic [3:0] SER_IDX_OPER_BASE = 4'h0;
  localparam logic [3:0] SER_IDX_DOUBT_BASE = 4'h5;
  localparam logic [3:0] SER_IDX_QUEUE = 4'hA;
  localparam logic [3:0] SER_IDX_QCOUNT = 4'hB;
  // Questionable bit for adjustment failures
  localparam int SER_ADJ_FAIL_BIT = 0;
  // Error queue
  localparam int SER_CODE_W = 16;
  localparam int SER_Q_DEPTH = 8;
  localparam int SER_Q_AW = 3;
  localparam logic [3:0] SER_Q_FULL = 4'h8;
  localparam logic [15:0] SER_NO_ERROR = 16'h0000;
endpackage : ser_pkg

//--- design/ser_top.sv
//
// Overview of operation
// - All status parts are fifteen bits wide.
// - Live state mirrors hardware, reads leave it.
// - Latched flags clear when read.
// - Rise filter latches zero to one changes.
// - Fall filter latches one to zero changes.
// - Masked flag raises the group summary bit.
// - Mask selects flags reaching status byte.
// - Preset: rise all ones, fall/mask zero.
// - Instrument reset leaves status parts alone.
// - Doubtful bit zero flags adjustment failure.
// - Queue read pops oldest, empty gives zero.
// - Codes positive device, negative language errors.
module ser_top
  import ser_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [14:0] oper_cond_in,
  input wire logic [14:0] doubt_cond_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_idx,
  input wire logic [15:0] reg_wdata,
  input wire logic status_preset,
  input wire logic err_push,
  input wire logic [15:0] err_code,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic oper_summary,
  output logic doubt_summary
);
  logic [14:0] cond_a [SER_GROUPS];
  logic [14:0] rise_a [SER_GROUPS];
  logic [14:0] fall_a [SER_GROUPS];
  logic [14:0] event_a [SER_GROUPS];
  logic [14:0] enable_a [SER_GROUPS];
  logic summ_a [SER_GROUPS];
  logic [14:0] raw_a [SER_GROUPS];
  logic [15:0] q_mem [SER_Q_DEPTH];
  logic [2:0] q_head_reg;
  logic [2:0] q_tail_reg;
  logic [3:0] q_count_reg;
  logic q_pop;
  logic q_push;
  logic [15:0] rd_mux;
  logic [15:0] rdata_reg;
  logic rvalid_reg;

  function automatic logic in_group(input logic [3:0] idx,
                                    input logic [3:0] base);
    in_group = (idx >= base) && (idx < base + 4'(SER_PARTS));
  endfunction : in_group

  function automatic logic [2:0] part_of(input logic [3:0] idx,
                                         input logic [3:0] base);
    logic [3:0] diff;
    diff = idx - base;
    part_of = diff[2:0];
  endfunction : part_of

  // Bit SER_ADJ_FAIL_BIT of the doubtful group carries adjustment failures
  assign raw_a[0] = oper_cond_in;
  assign raw_a[1] = doubt_cond_in;

  // Only writes and the preset input alter settings; no command reset reaches here
  generate
    for (genvar g = 0; g < SER_GROUPS; g++) begin : g_grp
      localparam logic [3:0] BASE = 4'(g * SER_PARTS);
      ser_group u_grp (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cond_in(raw_a[g]),
        .wr_en(reg_wr && in_group(reg_idx, BASE)),
        .wr_part(part_of(reg_idx, BASE)),
        .wr_data(reg_wdata[14:0]),
        .preset(status_preset),
        .rd_clear(reg_rd && in_group(reg_idx, BASE)
                  && part_of(reg_idx, BASE) == SER_PART_FLAGS),
        .cond_reg(cond_a[g]),
        .rise_reg(rise_a[g]),
        .fall_reg(fall_a[g]),
        .event_reg(event_a[g]),
        .enable_reg(enable_a[g]),
        .summary_reg(summ_a[g])
      );
    end
  endgenerate

  assign oper_summary = summ_a[0];
  assign doubt_summary = summ_a[1];

  assign q_pop = reg_rd && reg_idx == SER_IDX_QUEUE && q_count_reg != 4'h0;
  assign q_push = err_push && (q_count_reg != SER_Q_FULL || q_pop);

  always_comb begin
    rd_mux = 16'h0000;
    for (int g = 0; g < SER_GROUPS; g++) begin
      if (in_group(reg_idx, 4'(g * SER_PARTS))) begin
        case (part_of(reg_idx, 4'(g * SER_PARTS)))
          SER_PART_LIVE: rd_mux = {1'b0, cond_a[g]};
          SER_PART_MASK: rd_mux = {1'b0, enable_a[g]};
          SER_PART_FLAGS: rd_mux = {1'b0, event_a[g]};
          SER_PART_FALL: rd_mux = {1'b0, fall_a[g]};
          SER_PART_RISE: rd_mux = {1'b0, rise_a[g]};
          default: rd_mux = 16'h0000;
        endcase
      end
    end
    if (reg_idx == SER_IDX_QUEUE) begin
      rd_mux = (q_count_reg == 4'h0) ? SER_NO_ERROR : q_mem[q_head_reg];
    end else if (reg_idx == SER_IDX_QCOUNT) begin
      rd_mux = {12'h000, q_count_reg};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // Codes stored as signed two's complement, sign kept as given
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SER_Q_DEPTH; i++) begin
        q_mem[i] <= 16'h0000;
      end
    end else if (q_push) begin
      q_mem[q_tail_reg] <= err_code;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_head_reg <= 3'h0;
      q_tail_reg <= 3'h0;
      q_count_reg <= 4'h0;
    end else begin
      if (q_pop) begin
        q_head_reg <= q_head_reg + 3'h1;
      end
      if (q_push) begin
        q_tail_reg <= q_tail_reg + 3'h1;
      end
      case ({q_push, q_pop})
        2'b10: q_count_reg <= q_count_reg + 4'h1;
        2'b01: q_count_reg <= q_count_reg - 4'h1;
        default: q_count_reg <= q_count_reg;
      endcase
    end
  end

  sequence queue_read;
    reg_rd && reg_idx == SER_IDX_QUEUE;
  endsequence

  chk_queue_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
    queue_read and (q_count_reg == 4'h0) |=> reg_rvalid
      && reg_rdata == SER_NO_ERROR)
    else $error("empty queue read not zero");

  chk_queue_pop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    queue_read and (q_count_reg != 4'h0) and !err_push |=>
      q_count_reg == $past(q_count_reg) - 4'h1
      && reg_rdata == $past(q_mem[q_head_reg]))
    else $error("queue read did not pop oldest");

  chk_status_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_idx < SER_IDX_QUEUE |=> reg_rdata[15] == 1'b0)
    else $error("status read above fifteen bits");
endmodule : ser_top

//--- tb/ser_top_test.sv
module ser_top_test
  import ser_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk;
  logic rst_n;
  logic [14:0] oper_cond_in;
  logic [14:0] doubt_cond_in;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_idx;
  logic [15:0] reg_wdata;
  logic status_preset;
  logic err_push;
  logic [15:0] err_code;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic oper_summary;
  logic doubt_summary;
  int err_count;
  int checked;

  ser_top i_ser_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .oper_cond_in(oper_cond_in),
    .doubt_cond_in(doubt_cond_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .status_preset(status_preset), .err_push(err_push),
    .err_code(err_code), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .oper_summary(oper_summary), .doubt_summary(doubt_summary)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  function automatic logic [3:0] ix(input logic [3:0] b, input logic [2:0] p);
    return b + {1'b0, p};
  endfunction : ix

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    reg_idx = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    // Idle edge so a following call never re-raises the strobe at once
    tick();
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    reg_idx = idx;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    chk1("rvalid", 1'b1, reg_rvalid);
    chk16($sformatf("reg %h", idx), exp, reg_rdata);
    tick();
  endtask : rd

  task automatic cond(input logic [14:0] o, input logic [14:0] q);
    oper_cond_in = o;
    doubt_cond_in = q;
    repeat (5) tick();
  endtask : cond

  task automatic push(input logic [15:0] c);
    err_code = c;
    err_push = 1'b1;
    tick();
    err_push = 1'b0;
    tick();
  endtask : push

  task automatic test_end(input string name);
    $display("Test %s finished, mismatches so far %0d", name, err_count);
  endtask : test_end

  task automatic chk_preset_vals;
    logic [3:0] b;
    for (int g = 0; g < 2; g++) begin
      b = (g == 0) ? SER_IDX_OPER_BASE : SER_IDX_DOUBT_BASE;
      rd(ix(b, SER_PART_RISE), 16'h7FFF);
      rd(ix(b, SER_PART_FALL), 16'h0000);
      rd(ix(b, SER_PART_MASK), 16'h0000);
      rd(ix(b, SER_PART_FLAGS), 16'h0000);
    end
  endtask : chk_preset_vals

  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    oper_cond_in = 15'h0000;
    doubt_cond_in = 15'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 4'h0;
    reg_wdata = 16'h0000;
    status_preset = 1'b0;
    err_push = 1'b0;
    err_code = 16'h0000;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    tick();
    chk_preset_vals();
    wr(4'h3, 16'hFFFF);
    rd(4'h3, 16'h7FFF);
    wr(4'h0, 16'h1234);
    rd(4'h0, 16'h0000);
    rd(4'hC, 16'h0000);
    test_end("defaults");
    cond(15'h0008, 15'h0000);
    rd(4'h0, 16'h0008);
    rd(4'h0, 16'h0008);
    rd(4'h2, 16'h0008);
    rd(4'h2, 16'h0000);
    wr(4'h4, 16'h0000);
    cond(15'h0000, 15'h0000);
    rd(4'h2, 16'h0008);
    wr(4'h3, 16'h0000);
    cond(15'h0008, 15'h0000);
    cond(15'h0000, 15'h0000);
    rd(4'h2, 16'h0000);
    test_end("edges");
    cond(15'h0000, 15'h0002);
    chk1("doubt_summary", 1'b0, doubt_summary);
    wr(4'h6, 16'h0001);
    cond(15'h0000, 15'h0003);
    chk1("doubt_summary", 1'b1, doubt_summary);
    rd(4'h7, 16'h0003);
    chk1("doubt_summary", 1'b0, doubt_summary);
    wr(4'h1, 16'h0010);
    wr(4'h4, 16'h0010);
    cond(15'h0010, 15'h0000);
    chk1("oper_summary", 1'b1, oper_summary);
    test_end("summary");
    wr(4'h9, 16'h0000);
    status_preset = 1'b1;
    tick();
    status_preset = 1'b0;
    chk1("oper_summary", 1'b0, oper_summary);
    rd(4'h2, 16'h0010);
    chk_preset_vals();
    test_end("preset");
    rd(4'hA, 16'h0000);
    push(16'h0005);
    push(16'hFF9C);
    rd(4'hB, 16'h0002);
    rd(4'hA, 16'h0005);
    rd(4'hA, 16'hFF9C);
    rd(4'hA, 16'h0000);
    for (int i = 1; i <= 9; i++) push(16'(i));
    rd(4'hB, 16'h0008);
    for (int i = 1; i <= 8; i++) rd(4'hA, 16'(i));
    rd(4'hA, 16'h0000);
    test_end("queue");
    tally_and_finish();
  end
endmodule : ser_top_test
